// ===== hw/can_tx_filter_consts.vh
/*
 * named constants for the transmit buffer scheduler and identifier filter.
 * assumes it is included by bare name from the design file.
 */
`ifndef CAN_TX_FILTER_CONSTS_VH
`define CAN_TX_FILTER_CONSTS_VH

// message image and buffer store
`define MSG_BYTES      13
`define MSG_LAST       4'hc
`define MEM_WORDS      39
`define TXB_BASE0      6'h00
`define TXB_BASE1      6'h0d
`define TXB_BASE2      6'h1a
`define NUM_TXB        3

// fifo in the transmit byte path
`define FIFO_WIDTH     8
`define FIFO_DEPTH     16
`define FIFO_AW        4

// reset values
`define LOCAL_PRIORITY_FIELD_RST       8'h00
`define TXE_RST        3'h7
`define FLAGS_CLR      3'h0
`define BYTE_RST       8'h00

// acceptance filter modes
`define MODE_32        2'h0
`define MODE_16        2'h1
`define MODE_8         2'h2
`define MODE_CLOSED    2'h3

// hit codes
`define HIT0           2'h0
`define HIT1           2'h1
`define HIT2           2'h2
`define HIT3           2'h3

`endif

// ===== hw/can_tx_buffers_and_id_filter.v
/*
 * three transmit buffers with local-priority scheduling and abort handling,
 * a 16-byte fifo feeding the protocol engine, and the identifier acceptance
 * filter. assumes a protocol engine on sys_clk that signals arbitration,
 * completion and received identifiers, and a transceiver on the bus pins.
 */
`timescale 1ns/1ps
`include "can_tx_filter_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // clock and reset
   input  wire             sys_clk,
   input  wire             rst_n,
   input  wire             ce,
   input  wire             flush,
   // fill side
   input  wire [WIDTH-1:0] inData,
   input  wire             inValid,
   output wire             inReady,
   // drain side
   output wire [WIDTH-1:0] outData,
   output wire             outValid,
   input  wire             outReady
);
   localparam [AW:0] FULL  = DEPTH[AW:0];
   localparam [AW:0] EMPTY = 0;
   localparam [AW:0] ONE   = 1;

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wrPtr_r;
   reg [AW-1:0]    rdPtr_r;
   reg [AW:0]      count_r;
   wire            push;
   wire            pop;

   assign inReady  = (count_r != FULL);
   assign outValid = (count_r != EMPTY);
   assign outData  = mem[rdPtr_r];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always @(posedge sys_clk) begin
      if (ce && push) begin
         mem[wrPtr_r] <= inData;
      end
   end

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         wrPtr_r <= {AW{1'b0}};
         rdPtr_r <= {AW{1'b0}};
         count_r <= EMPTY;
      end else if (ce) begin
         if (flush) begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            count_r <= EMPTY;
         end else begin
            // depth is a power of two, so pointers wrap by overflow
            if (push) begin
               wrPtr_r <= wrPtr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
               rdPtr_r <= rdPtr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
               count_r <= count_r + ONE;
            end else if (pop && !push) begin
               count_r <= count_r - ONE;
            end
         end
      end
   end
endmodule // byte_fifo

////////////////////////////////////////////////////////////////////////////////
// Operation
// - three buffers, each a thirteen-byte message image like the receive buffer.
// - each buffer has its own eight-bit local priority written by the host.
// - after successful sending the buffer's empty flag is set again.
// - transmit interrupt when an unmasked empty flag is set; flags stay pollable.
// - among scheduled buffers the lowest priority value is sent first.
// - selection is redone at every arbitration, also after transmit errors.
// - host sets abort request; a message already in transmission is never aborted.
// - granted abort sets acknowledge and empty flag; acknowledge zero means sent.
// - four code bytes give patterns, four mask bytes mark don't-care bits.
// - accepted message sets receive-full and a two-bit hit code.
// - when several filters match, the lowest-numbered one is reported.
// - 32-bit mode compares whole extended or standard identifier with flag bits.
// - 16-bit mode runs two filters over the first two identifier bytes.
// - 8-bit mode runs four filters over the first identifier byte.
// - closed mode never copies a message nor sets receive-full.
// - stuff bit between ID16 and ID15 makes second byte compare shifted right.
// - transmit pin low for dominant, high for recessive.
module can_tx_buffers_and_id_filter (
   // clock, reset, enable
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        ce,
   // host buffer loading
   input  wire        loadWe,
   input  wire [1:0]  loadBuf,
   input  wire [3:0]  loadIdx,
   input  wire [7:0]  loadData,
   input  wire        prioWe,
   input  wire [1:0]  prioBuf,
   input  wire [7:0]  prioData,
   // host transmit flags and control
   input  wire [2:0]  txEmptyClr,
   input  wire [2:0]  abortReqSet,
   input  wire [2:0]  txIrqEnable,
   output wire [2:0]  txEmptyFlag,
   output wire [2:0]  abortReqFlag,
   output wire [2:0]  abortAckFlag,
   output wire        txIrq,
   // protocol engine, transmit side
   input  wire        arbStart,
   input  wire        txDone,
   input  wire        txFail,
   output wire        txRequest,
   output wire [1:0]  txActiveBuf,
   output wire [7:0]  txByteData,
   output wire        txByteValid,
   input  wire        txByteReady,
   // acceptance filter setup
   input  wire [1:0]  filterMode,
   input  wire [31:0] acceptCode,
   input  wire [31:0] acceptMask,
   // protocol engine, receive side
   input  wire        rxIdValid,
   input  wire [31:0] rxIdBytes,
   input  wire        rxExtended,
   input  wire        rxStuff1615,
   input  wire        rxFrameOk,
   input  wire        rxFullClr,
   output wire        rxFullFlag,
   output wire [1:0]  filterHitCode,
   output wire        rxCopy,
   output wire        rxOverrun,
   // bus pins and engine bit path
   input  wire        busRxPin,
   output wire        busRxBit,
   input  wire        txDominant,
   output wire        busTxPin
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_LOAD = 2'h1;
   localparam [1:0] ST_SEND = 2'h2;

   reg  [7:0]  txMem [0:`MEM_WORDS-1];
   reg  [2:0]  txe_r;
   reg  [2:0]  abort_request_bit_r;
   reg  [2:0]  abort_acknowledge_flag_r;
   reg  [23:0] local_priority_field_r;
   wire [2:0]  txeNxt;
   wire [2:0]  abtRqNxt;
   wire [2:0]  abtAkNxt;
   wire [23:0] prioNxt;
   reg  [1:0]  state_r;
   reg  [1:0]  state_nxt;
   reg  [1:0]  active_r;
   reg  [3:0]  byteCnt_r;
   reg         selValid;
   reg  [1:0]  selIdx;
   reg  [7:0]  selPrio;
   integer     k;
   wire [2:0]  sched;
   wire [5:0]  loadAddr;
   wire [5:0]  readAddr;
   wire        fifoInReady;
   wire        fifoFlush;
   wire        pushByte;

   function [5:0] bufBase;
      input [1:0] b;
      begin
         case (b)
            2'h1:    bufBase = `TXB_BASE1;
            2'h2:    bufBase = `TXB_BASE2;
            default: bufBase = `TXB_BASE0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // buffer store; writes to a scheduled buffer are dropped
   assign loadAddr = bufBase(loadBuf) + {2'h0, loadIdx};
   assign readAddr = bufBase(active_r) + {2'h0, byteCnt_r};

   always @(posedge sys_clk) begin
      if (ce && loadWe && loadBuf < `NUM_TXB && loadIdx <= `MSG_LAST &&
          txe_r[loadBuf]) begin
         txMem[loadAddr] <= loadData;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-buffer flags
   genvar i;
   generate
      for (i = 0; i < `NUM_TXB; i = i + 1) begin : gBuf
         wire inFlight = (state_r != ST_IDLE) && (active_r == i);
         wire sentOk   = txDone && (state_r == ST_SEND) && (active_r == i);
         // in-flight buffers wait; the grant comes after a failed attempt, a sent one drops the request
         wire grant    = abort_request_bit_r[i] && !txe_r[i] && !inFlight;
         assign txeNxt[i]   = txe_r[i] ? ~txEmptyClr[i]
                                       : (sentOk | grant);
         assign abtRqNxt[i] = txeNxt[i] ? 1'b0 : (abort_request_bit_r[i] | abortReqSet[i]);
         assign abtAkNxt[i] = grant ? 1'b1 :
                              (sentOk | (txe_r[i] & txEmptyClr[i])) ? 1'b0 :
                              abort_acknowledge_flag_r[i];
         assign prioNxt[8*i+7:8*i] = (prioWe && prioBuf == i) ? prioData
                                                              : local_priority_field_r[8*i+7:8*i];
         assign sched[i] = ~txe_r[i] & ~abort_request_bit_r[i];
      end
   endgenerate

   assign txEmptyFlag  = txe_r;
   assign abortReqFlag = abort_request_bit_r;
   assign abortAckFlag = abort_acknowledge_flag_r;
   assign txIrq        = |(txe_r & txIrqEnable);

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         txe_r   <= `TXE_RST;
         abort_request_bit_r <= `FLAGS_CLR;
         abort_acknowledge_flag_r <= `FLAGS_CLR;
         local_priority_field_r  <= {`NUM_TXB{`LOCAL_PRIORITY_FIELD_RST}};
      end else if (ce) begin
         txe_r   <= txeNxt;
         abort_request_bit_r <= abtRqNxt;
         abort_acknowledge_flag_r <= abtAkNxt;
         local_priority_field_r  <= prioNxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // lowest priority value wins; ties go to the lower buffer number
   always @* begin
      selValid = 1'b0;
      selIdx   = 2'h0;
      selPrio  = `LOCAL_PRIORITY_FIELD_RST;
      for (k = 0; k < `NUM_TXB; k = k + 1) begin
         if (sched[k] && (!selValid || local_priority_field_r[8*k+:8] < selPrio)) begin
            selValid = 1'b1;
            selIdx   = k[1:0];
            selPrio  = local_priority_field_r[8*k+:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // scheduler: pick at arbitration, stream image into fifo, await outcome
   assign pushByte  = (state_r == ST_LOAD) && fifoInReady;
   assign fifoFlush = (state_r == ST_SEND) && (txDone || txFail);

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (arbStart && selValid) begin
               state_nxt = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (pushByte && byteCnt_r == `MSG_LAST) begin
               state_nxt = ST_SEND;
            end
         end
         ST_SEND: begin
            // a failed attempt goes back to idle so the next arbitration re-picks
            if (txDone || txFail) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         state_r   <= ST_IDLE;
         active_r  <= 2'h0;
         byteCnt_r <= 4'h0;
      end else if (ce) begin
         state_r <= state_nxt;
         if (state_r == ST_IDLE && state_nxt == ST_LOAD) begin
            active_r  <= selIdx;
            byteCnt_r <= 4'h0;
         end else if (pushByte) begin
            byteCnt_r <= byteCnt_r + 4'h1;
         end
      end
   end

   assign txRequest   = (state_r != ST_IDLE);
   assign txActiveBuf = active_r;

   byte_fifo #(
      .WIDTH (`FIFO_WIDTH),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) uTxFifo (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .flush    (fifoFlush),
      .inData   (txMem[readAddr]),
      .inValid  (state_r == ST_LOAD),
      .inReady  (fifoInReady),
      .outData  (txByteData),
      .outValid (txByteValid),
      .outReady (txByteReady)
   );

   ////////////////////////////////////////////////////////////////////////////
   // acceptance filter
   wire [7:0] idB0 = rxIdBytes[31:24];
   wire [7:0] idB1 = rxIdBytes[23:16];
   wire [7:0] idB2 = rxIdBytes[15:8];
   wire [7:0] idB3 = rxIdBytes[7:0];
   // the shift register still lacks ID15 when byte two is compared
   wire       bugHit = rxExtended && rxStuff1615 && (filterMode != `MODE_8);
   wire [7:0] idB1Cmp = bugHit ? {idB0[0], idB1[7:1]} : idB1;
   wire [3:0] byteOk;

   generate
      for (i = 0; i < 4; i = i + 1) begin : gFlt
         wire [7:0] code = acceptCode[31-8*i:24-8*i];
         wire [7:0] mask = acceptMask[31-8*i:24-8*i];
         reg  [7:0] idSel;
         always @* begin
            idSel = idB0;
            case (filterMode)
               `MODE_32: idSel = (i == 0) ? idB0 : (i == 1) ? idB1Cmp :
                                 (i == 2) ? idB2 : idB3;
               `MODE_16: idSel = (i % 2 == 0) ? idB0 : idB1Cmp;
               default:  idSel = idB0;
            endcase
         end
         assign byteOk[i] = ~|((idSel ^ code) & ~mask);
      end
   endgenerate

   reg       fltAcc;
   reg [1:0] fltHit;
   always @* begin
      fltAcc = 1'b0;
      fltHit = `HIT0;
      case (filterMode)
         `MODE_32: begin
            // standard frames carry no third and fourth byte
            fltAcc = byteOk[0] & byteOk[1] &
                     (~rxExtended | (byteOk[2] & byteOk[3]));
         end
         `MODE_16: begin
            fltAcc = (byteOk[0] & byteOk[1]) | (byteOk[2] & byteOk[3]);
            fltHit = (byteOk[0] & byteOk[1]) ? `HIT0 : `HIT1;
         end
         `MODE_8: begin
            fltAcc = |byteOk;
            fltHit = byteOk[0] ? `HIT0 : byteOk[1] ? `HIT1 :
                     byteOk[2] ? `HIT2 : `HIT3;
         end
         default: fltAcc = 1'b0;
      endcase
   end

   reg       accPend_r;
   reg [1:0] hitPend_r;
   reg       rxFull_r;
   reg [1:0] hit_r;
   reg       rxCopy_r;
   reg       rxOvr_r;
   wire      rxSet = rxFrameOk && accPend_r && filterMode != `MODE_CLOSED && !rxFull_r;

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         accPend_r <= 1'b0;
         hitPend_r <= `HIT0;
         rxFull_r  <= 1'b0;
         hit_r     <= `HIT0;
         rxCopy_r  <= 1'b0;
         rxOvr_r   <= 1'b0;
      end else if (ce) begin
         if (rxIdValid) begin
            accPend_r <= fltAcc;
            hitPend_r <= fltHit;
         end else if (rxFrameOk) begin
            accPend_r <= 1'b0;
         end
         if (rxSet) begin
            rxFull_r <= 1'b1;
            hit_r    <= hitPend_r;
         end else if (rxFullClr) begin
            rxFull_r <= 1'b0;
         end
         rxCopy_r <= rxSet;
         rxOvr_r  <= rxFrameOk && accPend_r && filterMode != `MODE_CLOSED && rxFull_r;
      end
   end

   assign rxFullFlag    = rxFull_r;
   assign filterHitCode = hit_r;
   assign rxCopy        = rxCopy_r;
   assign rxOverrun     = rxOvr_r;

   ////////////////////////////////////////////////////////////////////////////
   // bus pins; receive pin is asynchronous to sys_clk
   reg rxMeta_r;
   reg rxSync_r;
   reg tx_r;
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         rxMeta_r <= 1'b1;
         rxSync_r <= 1'b1;
         tx_r     <= 1'b1;
      end else if (ce) begin
         rxMeta_r <= busRxPin;
         rxSync_r <= rxMeta_r;
         tx_r     <= ~txDominant;
      end
   end

   assign busRxBit = rxSync_r;
   assign busTxPin = tx_r;
endmodule // can_tx_buffers_and_id_filter

// ===== dv/can_engine_model.sv
/*
 * protocol engine stand-in: drains the transmit byte fifo with random
 * stalls, reports each popped byte, then ends the frame with done or fail.
 * assumes sys_clk and the sync active-low reset of the block.
 */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module can_engine_model (
   // clock and reset
   input  logic       sys_clk,
   input  logic       rst_n,
   // fifo drain side
   input  logic [7:0] txByteData,
   input  logic       txByteValid,
   output logic       txByteReady,
   // scenario control
   input  logic       hold,
   input  logic       failNext,
   // observed bytes and frame outcome
   output logic       popSeen,
   output logic [7:0] popData,
   output logic       txDone,
   output logic       txFail
);
   int popCnt;
   initial begin
      {txByteReady, popSeen, popData, txDone, txFail} = '0;
      popCnt = 0;
   end
   always @(posedge sys_clk) begin
      popSeen <= 1'b0;
      txDone <= 1'b0;
      txFail <= 1'b0;
      // stalls keep bytes piling up in the fifo
      txByteReady <= !hold && ($urandom_range(3) != 0);
      if (!rst_n) begin
         popCnt <= 0;
      end else if (popCnt == 13) begin
         popCnt <= 0;
         txDone <= !failNext;
         txFail <= failNext;
      end else if (txByteValid && txByteReady) begin
         popSeen <= 1'b1;
         popData <= txByteData;
         popCnt <= popCnt + 1;
      end
   end
endmodule // can_engine_model

// ===== dv/can_tx_filter_sva.sv
/*
 * concurrent checks on the top ports of the buffer and filter block.
 * assumes one clock, sys_clk, and rst_n synchronous active low.
 */
`timescale 1ns/1ps
`include "can_tx_filter_consts.vh"
////////////////////////////////////////////////////////////////////////////////
module can_tx_filter_checker (
   input logic       sys_clk,
   input logic       rst_n,
   input logic       ce,
   input logic [2:0] txEmptyClr,
   input logic [2:0] txIrqEnable,
   input logic [2:0] txEmptyFlag,
   input logic [2:0] abortReqFlag,
   input logic [2:0] abortAckFlag,
   input logic       txIrq,
   input logic       txDone,
   input logic       txRequest,
   input logic [1:0] txActiveBuf,
   input logic [1:0] filterMode,
   input logic       rxFrameOk,
   input logic       rxFullClr,
   input logic       rxFullFlag,
   input logic       rxCopy,
   input logic       txDominant,
   input logic       busTxPin
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   reset_empty_a: assert property (disable iff (1'b0)
      !rst_n && ce |=> txEmptyFlag == `TXE_RST && abortReqFlag == 3'h0 && abortAckFlag == 3'h0)
      else $error("buffers not released by reset");
   irq_mask_a: assert property (txIrq == |(txEmptyFlag & txIrqEnable))
      else $error("transmit interrupt disagrees with flags and mask");
   sched_clear_a: assert property (ce && (txEmptyClr & txEmptyFlag) != 3'h0
      |=> (txEmptyFlag & $past(txEmptyClr & txEmptyFlag)) == 3'h0)
      else $error("empty flag not cleared by schedule");
   sent_release_a: assert property (ce && txRequest && txDone ##1 !txRequest
      |-> txEmptyFlag[$past(txActiveBuf)] && !abortAckFlag[$past(txActiveBuf)])
      else $error("sent buffer not released");
   no_abort_active_a: assert property (ce && txRequest && !abortAckFlag[txActiveBuf]
      |=> !abortAckFlag[$past(txActiveBuf)])
      else $error("active message aborted");
   closed_never_a: assert property (filterMode == `MODE_CLOSED
      && $past(filterMode) == `MODE_CLOSED && !rxFullFlag |=> !rxFullFlag)
      else $error("receive flag set in closed mode");
   flag_hold_a: assert property (rxFullFlag && !rxFullClr |=> rxFullFlag)
      else $error("receive flag dropped without clear");
   copy_flag_a: assert property (rxCopy |-> rxFullFlag && $past(rxFrameOk))
      else $error("copy without flag or frame end");
   tx_pin_a: assert property (ce |=> busTxPin == !$past(txDominant))
      else $error("transmit pin polarity wrong");
endmodule // can_tx_filter_checker

bind can_tx_buffers_and_id_filter can_tx_filter_checker i_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .txEmptyClr(txEmptyClr),
   .txIrqEnable(txIrqEnable), .txEmptyFlag(txEmptyFlag), .abortReqFlag(abortReqFlag),
   .abortAckFlag(abortAckFlag), .txIrq(txIrq), .txDone(txDone), .txRequest(txRequest),
   .txActiveBuf(txActiveBuf), .filterMode(filterMode), .rxFrameOk(rxFrameOk),
   .rxFullClr(rxFullClr), .rxFullFlag(rxFullFlag), .rxCopy(rxCopy),
   .txDominant(txDominant), .busTxPin(busTxPin));

// ===== dv/tb.sv
/*
 * self-checking bench: host-side stimulus, engine model on the byte fifo,
 * expected bytes and hit codes queued and compared as results appear.
 * assumes the design and constants header from hw/ on the include path.
 */
`timescale 1ns/1ps
`include "can_tx_filter_consts.vh"
////////////////////////////////////////////////////////////////////////////////
module tb;
   logic        sys_clk, rst_n, ce, loadWe, prioWe, arbStart, hold, failNext, pinsRun;
   logic        rxIdValid, rxExtended, rxStuff1615, rxFrameOk, rxFullClr, busRxPin, txDominant;
   logic        txIrq, txRequest, txByteValid, txByteReady, txDone, txFail, popSeen;
   logic        rxFullFlag, rxCopy, rxOverrun, busRxBit, busTxPin;
   logic [1:0]  loadBuf, prioBuf, filterMode, txActiveBuf, filterHitCode;
   logic [3:0]  loadIdx;
   logic [7:0]  loadData, prioData, txByteData, popData;
   logic [2:0]  txEmptyClr, abortReqSet, txIrqEnable, txEmptyFlag, abortReqFlag, abortAckFlag;
   logic [2:0]  pend;
   logic [31:0] acceptCode, acceptMask, rxIdBytes;
   logic [7:0]  img [3][13];
   logic [7:0]  local_priority_field [3];
   logic [7:0]  byteQ [$];
   logic [1:0]  hitQ [$];
   int          failures = 0;
   int          comparisons = 0;
   int          cycles = 0;

   can_tx_buffers_and_id_filter i_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .loadWe(loadWe), .loadBuf(loadBuf),
      .loadIdx(loadIdx), .loadData(loadData), .prioWe(prioWe), .prioBuf(prioBuf),
      .prioData(prioData), .txEmptyClr(txEmptyClr), .abortReqSet(abortReqSet),
      .txIrqEnable(txIrqEnable), .txEmptyFlag(txEmptyFlag), .abortReqFlag(abortReqFlag),
      .abortAckFlag(abortAckFlag), .txIrq(txIrq), .arbStart(arbStart), .txDone(txDone),
      .txFail(txFail), .txRequest(txRequest), .txActiveBuf(txActiveBuf),
      .txByteData(txByteData), .txByteValid(txByteValid), .txByteReady(txByteReady),
      .filterMode(filterMode), .acceptCode(acceptCode), .acceptMask(acceptMask),
      .rxIdValid(rxIdValid), .rxIdBytes(rxIdBytes), .rxExtended(rxExtended),
      .rxStuff1615(rxStuff1615), .rxFrameOk(rxFrameOk), .rxFullClr(rxFullClr),
      .rxFullFlag(rxFullFlag), .filterHitCode(filterHitCode), .rxCopy(rxCopy),
      .rxOverrun(rxOverrun), .busRxPin(busRxPin), .busRxBit(busRxBit),
      .txDominant(txDominant), .busTxPin(busTxPin));

   can_engine_model i_eng (
      .sys_clk(sys_clk), .rst_n(rst_n), .txByteData(txByteData),
      .txByteValid(txByteValid), .txByteReady(txByteReady), .hold(hold),
      .failNext(failNext), .popSeen(popSeen), .popData(popData), .txDone(txDone),
      .txFail(txFail));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // long early stall so the fifo fills while the engine waits
   initial begin
      hold = 1'b1;
      #400 hold = 1'b0;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (popSeen) check(popData, byteQ.pop_front());
      if (rxCopy) check(filterHitCode, hitQ.pop_front());
      if (cycles == 5000) begin
         failures++;
         give_verdict();
      end
   end
   always @(negedge sys_clk) begin
      if (pinsRun) begin
         busRxPin <= $urandom_range(1);
         txDominant <= $urandom_range(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic load(input int b);
      for (int i = 0; i < 13; i++) begin
         img[b][i] = $urandom_range(255);
         loadWe = 1'b1;
         loadBuf = b;
         loadIdx = i;
         loadData = img[b][i];
         tick(1);
      end
      loadWe = 1'b0;
   endtask
   task automatic setprio(input int b, input logic [7:0] p);
      local_priority_field[b] = p;
      prioWe = 1'b1;
      prioBuf = b;
      prioData = p;
      tick(1);
      prioWe = 1'b0;
   endtask
   task automatic sched(input logic [2:0] m);
      pend = pend | m;
      txEmptyClr = m;
      tick(1);
      txEmptyClr = 3'h0;
   endtask
   function automatic int pick();
      int e;
      e = -1;
      for (int i = 0; i < 3; i++)
         if (pend[i] && (e < 0 || local_priority_field[i] < local_priority_field[e])) e = i;
      return e;
   endfunction
   task automatic send(input logic fail, input logic abt);
      int e;
      e = pick();
      failNext = fail;
      for (int i = 0; i < 13; i++) byteQ.push_back(img[e][i]);
      arbStart = 1'b1;
      tick(1);
      arbStart = 1'b0;
      check(txRequest, 1);
      check(txActiveBuf, e);
      if (abt) begin
         abortReqSet = 3'h1 << e;
         tick(1);
         abortReqSet = 3'h0;
      end
      for (int k = 0; k < 300 && txRequest === 1'b1; k++) tick(1);
      if (!fail) pend[e] = 1'b0;
      tick(1);
      check(txEmptyFlag, 3'(~pend));
      check(abortAckFlag, 3'h0);
   endtask
   task automatic filt(input logic [1:0] m, input logic [31:0] c, k, id,
                       input logic ext, stf, acc, input logic [1:0] h);
      if (acc) hitQ.push_back(h);
      filterMode = m;
      acceptCode = c;
      acceptMask = k;
      rxIdBytes = id;
      rxExtended = ext;
      rxStuff1615 = stf;
      // second frame on a full flag must overrun, not copy
      for (int n = 0; n < 2; n++) begin
         rxIdValid = 1'b1;
         tick(1);
         rxIdValid = 1'b0;
         rxFrameOk = 1'b1;
         tick(1);
         rxFrameOk = 1'b0;
         check(rxOverrun, acc & n);
      end
      tick(1);
      check(rxFullFlag, acc);
      rxFullClr = 1'b1;
      tick(1);
      rxFullClr = 1'b0;
      tick(1);
      check(rxFullFlag, 0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      busRxPin = 1'b1;
      {loadWe, prioWe, arbStart, failNext, pinsRun, rxIdValid, rxExtended} = '0;
      {rxStuff1615, rxFrameOk, rxFullClr, txDominant} = '0;
      {loadBuf, loadIdx, loadData, prioBuf, prioData, txEmptyClr, abortReqSet} = '0;
      {txIrqEnable, filterMode, acceptCode, acceptMask, rxIdBytes, pend} = '0;
      void'($urandom(88693));
      tick(6);
      rst_n = 1'b1;
      tick(1);
      check({txEmptyFlag, abortReqFlag, abortAckFlag, rxFullFlag, busTxPin, txRequest},
            {3'h7, 3'h0, 3'h0, 3'b010});
      $display("test reset done");
      pinsRun = 1'b1;
      for (int b = 0; b < 3; b++) begin
         load(b);
         setprio(b, $urandom_range(255));
      end
      sched(3'h7);
      // a load into a scheduled buffer must be dropped
      loadWe = 1'b1;
      {loadBuf, loadIdx} = '0;
      loadData = ~img[0][0];
      tick(1);
      loadWe = 1'b0;
      send(1'b1, 1'b0);
      setprio(pick(), 8'hff);
      repeat (3) send(1'b0, 1'b0);
      $display("test transmit priority done");
      sched(3'b100);
      txIrqEnable = 3'b100;
      tick(1);
      check(txIrq, 0);
      abortReqSet = 3'b100;
      tick(1);
      abortReqSet = 3'h0;
      tick(2);
      check({abortAckFlag, txEmptyFlag, txIrq}, {3'b100, 3'b111, 1'b1});
      pend = 3'h0;
      sched(3'b100);
      send(1'b0, 1'b1);
      $display("test abort done");
      filt(`MODE_32, 32'h12345678, 32'h0, 32'h12345678, 1, 0, 1, `HIT0);
      filt(`MODE_32, 32'h12345678, 32'h0, 32'h12345679, 1, 0, 0, `HIT0);
      filt(`MODE_32, 32'h12345678, 32'h0, 32'h123400ff, 0, 0, 1, `HIT0);
      filt(`MODE_32, 32'h12345678, 32'h000000ff, 32'h12345600, 1, 0, 1, `HIT0);
      filt(`MODE_16, 32'haabbccdd, 32'h0, 32'hccdd0000, 1, 0, 1, `HIT1);
      filt(`MODE_16, 32'haabbaabb, 32'h0, 32'haabb0000, 1, 0, 1, `HIT0);
      filt(`MODE_8, 32'h11223344, 32'h0, 32'h44000000, 0, 0, 1, `HIT3);
      filt(`MODE_8, 32'h55666677, 32'h0, 32'h66000000, 0, 0, 1, `HIT1);
      filt(`MODE_8, 32'h11223344, 32'h0, 32'h99000000, 0, 0, 0, `HIT0);
      filt(`MODE_CLOSED, 32'h0, 32'hffffffff, 32'h12345678, 1, 0, 0, `HIT0);
      filt(`MODE_32, 32'h03e00000, 32'h0000ffff, 32'h03c00000, 1, 1, 1, `HIT0);
      filt(`MODE_32, 32'h03c00000, 32'h0000ffff, 32'h03c00000, 1, 1, 0, `HIT0);
      filt(`MODE_32, 32'h03c00000, 32'h00f1ffff, 32'h03c00000, 1, 1, 1, `HIT0);
      $display("test acceptance filter done");
      pinsRun = 1'b0;
      tick(1);
      txDominant = 1'b1;
      busRxPin = 1'b0;
      tick(3);
      check({busTxPin, busRxBit}, 2'b00);
      $display("test pins done");
      give_verdict();
   end
endmodule // tb
